// >>> hdl/iqc_command.sv
// Purpose: global_command register and queue setup on action_request
// Assumes: register port on ref_clk; base/length inputs on ref_clk
// Notes:   reads return one cycle after regRdEn; unmapped reads give 0
//
// What this block does
// - rx queue configure bits 31..28, used on request
// - tx queue configure bits 27..24, used on request
// - config queue configure bit 21, used on request
// - clear channel bit keeps queue setup unchanged
// - clear config bit leaves config queue alone
// - set bit reconfigures queue, replacing earlier setup
// - channel queue loads base and length registers
// - config queue loads base and length registers
// - bits 23:22 and 20:14 read zero
// - configure bits read/write, reset to zero
// - bit 0 request self-clears, acts on held bits

`timescale 1ns/1ps

module iqc_command (
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   input  wire logic                 regWrEn,
   input  wire logic                 regRdEn,
   input  wire logic [11:0]          regAddr,
   input  wire logic [31:0]          regWrData,
   output logic      [31:0]          regRdData_q,
   input  wire logic [8:0][31:0]     qBaseIn,
   input  wire logic [8:0][31:0]     qLenIn,
   output logic      [8:0][31:0]     qBase_q,
   output logic      [8:0][31:0]     qLen_q,
   output logic      [8:0]           qValid_q,
   output logic                      arPend_q,
   output logic                      arAck_q,
   output logic      [8:0]           arMask_q
);

   // ----------------------------------------------------------------
   // command register
   // ----------------------------------------------------------------
   logic [3:0] rxCfg_q;
   logic [3:0] rxCfg_d;
   logic [3:0] txCfg_q;
   logic [3:0] txCfg_d;
   logic       cfgQ_q;
   logic       cfgQ_d;
   logic       arPend_d;
   logic       cmdWr;
   logic       cmdHit;
   logic [8:0] qSel;

   assign cmdHit = (regAddr == iqc_pkg::GLOBAL_COMMAND_OFS);
   assign cmdWr  = regWrEn && cmdHit;
   assign qSel   = {cfgQ_q, txCfg_q, rxCfg_q};

   always_comb begin
      rxCfg_d  = rxCfg_q;
      txCfg_d  = txCfg_q;
      cfgQ_d   = cfgQ_q;
      // self-clears after the one cycle in which it is executed
      arPend_d = 1'b0;
      if (cmdWr) begin
         rxCfg_d = regWrData[iqc_pkg::RXQ_MSB:iqc_pkg::RXQ_LSB];
         txCfg_d = regWrData[iqc_pkg::TXQ_MSB:iqc_pkg::TXQ_LSB];
         cfgQ_d  = regWrData[iqc_pkg::CFGQ_BIT];
         // a new request in the execute cycle is kept, not lost
         arPend_d = regWrData[iqc_pkg::AR_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rxCfg_q  <= iqc_pkg::CH_CFG_RST;
         txCfg_q  <= iqc_pkg::CH_CFG_RST;
         cfgQ_q   <= 1'b0;
         arPend_q <= 1'b0;
      end else begin
         rxCfg_q  <= rxCfg_d;
         txCfg_q  <= txCfg_d;
         cfgQ_q   <= cfgQ_d;
         arPend_q <= arPend_d;
      end
   end

   // ----------------------------------------------------------------
   // queue setup, one slot per queue
   // ----------------------------------------------------------------
   logic [8:0][31:0] qBase_d;
   logic [8:0][31:0] qLen_d;
   logic [8:0]       qValid_d;
   logic             arAck_d;
   logic [8:0]       arMask_d;

   genvar gi;
   generate
      for (gi = 0; gi < iqc_pkg::QUEUE_N; gi++) begin : g_queue
         always_comb begin
            qBase_d[gi]  = qBase_q[gi];
            qLen_d[gi]   = qLen_q[gi];
            qValid_d[gi] = qValid_q[gi];
            // base/length are taken as software left them beforehand
            if (arPend_q && qSel[gi]) begin
               qBase_d[gi]  = qBaseIn[gi];
               qLen_d[gi]   = qLenIn[gi];
               qValid_d[gi] = 1'b1;
            end
         end

         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               qBase_q[gi]  <= iqc_pkg::WORD_RST;
               qLen_q[gi]   <= iqc_pkg::WORD_RST;
               qValid_q[gi] <= 1'b0;
            end else begin
               qBase_q[gi]  <= qBase_d[gi];
               qLen_q[gi]   <= qLen_d[gi];
               qValid_q[gi] <= qValid_d[gi];
            end
         end

         load_sel_a: assert property (@(posedge ref_clk)
            disable iff (!resetn)
            arPend_q && qSel[gi] |=> qBase_q[gi] == $past(qBaseIn[gi])
               && qLen_q[gi] == $past(qLenIn[gi]) && qValid_q[gi])
            else $error("selected queue not loaded");

         keep_unsel_a: assert property (@(posedge ref_clk)
            disable iff (!resetn)
            !(arPend_q && qSel[gi]) |=> $stable(qBase_q[gi])
               && $stable(qLen_q[gi]) && $stable(qValid_q[gi]))
            else $error("unselected queue changed");
      end
   endgenerate

   // ----------------------------------------------------------------
   // acknowledge of the executed request
   // ----------------------------------------------------------------
   // the mask holds until the next request so software can still see
   // what the last request touched after the pulse has gone
   always_comb begin
      arAck_d  = arPend_q;
      arMask_d = arPend_q ? qSel : arMask_q;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         arAck_q  <= 1'b0;
         arMask_q <= iqc_pkg::QSEL_RST;
      end else begin
         arAck_q  <= arAck_d;
         arMask_q <= arMask_d;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [31:0] regRdData_d;
   logic [31:0] cmdView;

   always_comb begin
      cmdView = iqc_pkg::WORD_RST;
      cmdView[iqc_pkg::RXQ_MSB:iqc_pkg::RXQ_LSB] = rxCfg_q;
      cmdView[iqc_pkg::TXQ_MSB:iqc_pkg::TXQ_LSB] = txCfg_q;
      cmdView[iqc_pkg::CFGQ_BIT] = cfgQ_q;
      cmdView[iqc_pkg::AR_BIT]   = arPend_q;
      // a read in the cycle of a write returns the word as it stood
      regRdData_d = regRdData_q;
      if (regRdEn) begin
         regRdData_d = cmdHit ? cmdView : iqc_pkg::WORD_RST;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         regRdData_q <= iqc_pkg::WORD_RST;
      end else begin
         regRdData_q <= regRdData_d;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   rsv_zero_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      regRdData_q[23:22] == 2'h0 && regRdData_q[20:14] == 7'h00)
      else $error("reserved bits read nonzero");

   rx_store_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      cmdWr ##1 (regRdEn && cmdHit) |=>
         regRdData_q[31:28] == $past(regWrData[31:28], 2))
      else $error("rx configure bits not read back");

   tx_store_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      cmdWr |=> txCfg_q == $past(regWrData[27:24])
         && cfgQ_q == $past(regWrData[21]))
      else $error("tx or config bit not stored");

   cfg_hold_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      !cmdWr |=> $stable(rxCfg_q) && $stable(txCfg_q) && $stable(cfgQ_q))
      else $error("configure bits changed without write");

   ar_self_clr_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      cmdWr && regWrData[0] ##1 !cmdWr |=> !arPend_q)
      else $error("action request did not self-clear");

   ar_set_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      cmdWr && regWrData[0] |=> arPend_q ##1 arAck_q)
      else $error("action request not executed");

   ack_mask_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q |=> arAck_q && arMask_q == $past(qSel))
      else $error("acknowledge mask wrong");

   cfgq_keep_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q && !cfgQ_q |=> $stable(qBase_q[8]) && $stable(qLen_q[8]))
      else $error("config queue changed while not selected");

   cfgq_load_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q && cfgQ_q |=> qBase_q[8] == $past(qBaseIn[8]))
      else $error("config queue base not loaded");

   unmap_zero_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      regRdEn && !cmdHit |=> regRdData_q == 32'h0000_0000)
      else $error("unmapped read not zero");

   // ----------------------------------------------------------------
   // request sequencing and read port checks
   // ----------------------------------------------------------------
   tx_read_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      cmdWr ##1 (regRdEn && cmdHit) |=>
         regRdData_q[27:24] == $past(regWrData[27:24], 2)
         && regRdData_q[21] == $past(regWrData[21], 2))
      else $error("tx or config bits not read back");

   ar_cause_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q |-> $past(cmdWr) && $past(regWrData[0]))
      else $error("request executed without a write");

   // a write that lands in the execute cycle re-arms; the set wins
   ar_rearm_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q && cmdWr && regWrData[0] |=> arPend_q)
      else $error("request in execute cycle was lost");

   ar_one_cycle_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q && !(cmdWr && regWrData[0]) |=> !arPend_q)
      else $error("request stood longer than one cycle");

   ack_exec_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      !arPend_q |=> !arAck_q && $stable(arMask_q))
      else $error("acknowledge or mask moved without a request");

   unsel_mask_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q && !cfgQ_q |=> !arMask_q[8])
      else $error("config queue reported while not selected");

   // valid bits only rise; a queue is never unconfigured short of reset
   valid_keep_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      1'b1 |=> (qValid_q & $past(qValid_q)) == $past(qValid_q))
      else $error("configured queue lost its setup");

   cfgq_len_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      arPend_q && cfgQ_q |=>
         qLen_q[8] == $past(qLenIn[8]) && qValid_q[8])
      else $error("config queue length not loaded");

   rd_hold_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      !regRdEn |=> $stable(regRdData_q))
      else $error("read data changed without a read");

   low_zero_a: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      regRdData_q[13:1] == 13'h0000)
      else $error("unused low bits read nonzero");

   all_sel_c: cover property (@(posedge ref_clk) disable iff (!resetn)
      arPend_q && qSel == 9'h1FF);
   none_sel_c: cover property (@(posedge ref_clk) disable iff (!resetn)
      arPend_q && qSel == 9'h000);
   back_ar_c: cover property (@(posedge ref_clk) disable iff (!resetn)
      arPend_q && cmdWr && regWrData[0] ##1 arPend_q);
   reconf_c: cover property (@(posedge ref_clk) disable iff (!resetn)
      qValid_q[0] && arPend_q && rxCfg_q[0]);
   rw_same_c: cover property (@(posedge ref_clk) disable iff (!resetn)
      cmdWr && regRdEn && cmdHit);

endmodule // iqc_command

// >>> hdl/iqc_pkg.sv
// Purpose: constants for the interrupt queue configuration command block
// Assumes: one 32-bit command register in the local register space
// Notes:   queue index 0..3 receive ch0..3, 4..7 transmit ch0..3, 8 config

package iqc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int           ADDR_W       = 12;
   localparam int           DATA_W       = 32;
   localparam logic [11:0]  GLOBAL_COMMAND_OFS = 12'h000;

   // ----------------------------------------------------------------
   // global_command field positions
   // ----------------------------------------------------------------
   localparam int           CH_N         = 4;
   localparam int           QUEUE_N      = 9;
   localparam int           RXQ_LSB      = 28;
   localparam int           RXQ_MSB      = 31;
   localparam int           TXQ_LSB      = 24;
   localparam int           TXQ_MSB      = 27;
   localparam int           CFGQ_BIT     = 21;
   localparam int           AR_BIT       = 0;

   // ----------------------------------------------------------------
   // queue slots
   // ----------------------------------------------------------------
   localparam int           RXQ_BASE_IDX = 0;
   localparam int           TXQ_BASE_IDX = 4;
   localparam int           CFGQ_IDX     = 8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [3:0]   CH_CFG_RST   = 4'h0;
   localparam logic [31:0]  WORD_RST     = 32'h0000_0000;
   localparam logic [8:0]   QSEL_RST     = 9'h000;

endpackage : iqc_pkg

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the global_command queue setup block
// Assumes: single ref_clk domain, register port as plain strobes
// Notes:   queue model kept in arrays, compared after every request

`timescale 1ns/1ps

module testbench;

   // ------------------------------------------------------------
   // signals and model state
   // ------------------------------------------------------------
   logic                ref_clk;
   logic                resetn;
   logic                regWrEn;
   logic                regRdEn;
   logic [11:0]         regAddr;
   logic [31:0]         regWrData;
   logic [31:0]         regRdData_q;
   logic [8:0][31:0]    qBaseIn;
   logic [8:0][31:0]    qLenIn;
   logic [8:0][31:0]    qBase_q;
   logic [8:0][31:0]    qLen_q;
   logic [8:0]          qValid_q;
   logic                arPend_q;
   logic                arAck_q;
   logic [8:0]          arMask_q;
   integer              fail_count   = 0;
   integer              total_checks = 0;
   integer              cycles       = 0;
   integer              seed         = 32'h7b48;
   logic [31:0]         mBase [9];
   logic [31:0]         mLen  [9];
   logic [8:0]          mValid;
   logic [8:0]          mSel;
   logic [31:0]         w;

   iqc_command DUT (.ref_clk(ref_clk), .resetn(resetn), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData_q(regRdData_q), .qBaseIn(qBaseIn), .qLenIn(qLenIn),
      .qBase_q(qBase_q), .qLen_q(qLen_q), .qValid_q(qValid_q),
      .arPend_q(arPend_q), .arAck_q(arAck_q), .arMask_q(arMask_q));

   // ------------------------------------------------------------
   // clock, timeout and shared tasks
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // a full run needs about 280 cycles; 2000, about seven times that, means a hang
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWrEn   <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrEn   <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1 check("regRdData", regRdData_q, exp);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      resetn    = 1'b0;
      regWrEn   = 1'b0;
      regRdEn   = 1'b0;
      regAddr   = 12'h000;
      regWrData = 32'h0000_0000;
      qBaseIn   = '0;
      qLenIn    = '0;
      mValid    = 9'h000;
      for (int k = 0; k < 9; k++) begin
         mBase[k] = 32'h0000_0000;
         mLen[k]  = 32'h0000_0000;
      end
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(12'h000, 32'h0000_0000);
      check("qValid", {23'h0, qValid_q}, 32'h0000_0000);
      $display("test reset done");

      // configure bits held without a request change no queue
      wr(12'h000, 32'hFFFF_FFFE);
      #1 check("arPend", {31'h0, arPend_q}, 32'h0000_0000);
      rd(12'h000, 32'hFF20_0000);
      check("qValid", {23'h0, qValid_q}, 32'h0000_0000);
      wr(12'h004, 32'hFFFF_FFFF);
      rd(12'h004, 32'h0000_0000);
      rd(12'h000, 32'hFF20_0000);
      $display("test register access done");

      // random requests, reserved bits set at random too
      for (int i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         for (int k = 0; k < 9; k++) begin
            qBaseIn[k] <= $random(seed);
            qLenIn[k]  <= $random(seed);
         end
         w = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0001
             : ($random(seed) | 32'h0000_0001);
         for (int k = 0; k < 4; k++) begin
            mSel[k]     = w[28 + k];
            mSel[4 + k] = w[24 + k];
         end
         mSel[8] = w[21];
         wr(12'h000, w);
         #1 check("arPend", {31'h0, arPend_q}, 32'h0000_0001);
         for (int k = 0; k < 9; k++)
            if (mSel[k]) begin
               mBase[k]  = qBaseIn[k];
               mLen[k]   = qLenIn[k];
               mValid[k] = 1'b1;
            end
         @(posedge ref_clk);
         #1 check("arAck", {31'h0, arAck_q}, 32'h0000_0001);
         check("arMask", {23'h0, arMask_q}, {23'h0, mSel});
         check("arPend", {31'h0, arPend_q}, 32'h0000_0000);
         check("qValid", {23'h0, qValid_q}, {23'h0, mValid});
         for (int k = 0; k < 9; k++) begin
            check("qBase", qBase_q[k], mBase[k]);
            check("qLen", qLen_q[k], mLen[k]);
         end
         rd(12'h000, w & 32'hFF20_0000);
      end
      $display("test queue requests done");

      // a request written while the previous one executes is kept, and
      // a read in the same cycle as a write returns the old word
      @(posedge ref_clk);
      regWrEn   <= 1'b1;
      regAddr   <= 12'h000;
      regWrData <= 32'h1000_0001;
      @(posedge ref_clk);
      regWrData <= 32'h0200_0001;
      regRdEn   <= 1'b1;
      @(posedge ref_clk);
      regWrEn   <= 1'b0;
      regRdEn   <= 1'b0;
      #1 check("regRdData", regRdData_q, 32'h1000_0001);
      check("arPend", {31'h0, arPend_q}, 32'h0000_0001);
      check("arMask", {23'h0, arMask_q}, 32'h0000_0001);
      @(posedge ref_clk);
      #1 check("arPend", {31'h0, arPend_q}, 32'h0000_0000);
      check("arAck", {31'h0, arAck_q}, 32'h0000_0001);
      check("arMask", {23'h0, arMask_q}, 32'h0000_0020);
      check("regRdData", regRdData_q, 32'h1000_0001);
      mBase[0] = qBaseIn[0];
      mLen[0]  = qLenIn[0];
      mBase[5] = qBaseIn[5];
      mLen[5]  = qLenIn[5];
      mValid   = mValid | 9'h021;
      check("qValid", {23'h0, qValid_q}, {23'h0, mValid});
      for (int k = 0; k < 9; k++) begin
         check("qBase", qBase_q[k], mBase[k]);
         check("qLen", qLen_q[k], mLen[k]);
      end
      @(posedge ref_clk);
      #1 check("arAck", {31'h0, arAck_q}, 32'h0000_0000);
      $display("test request during execution done");

      // an asynchronous reset in mid-run clears every configured queue
      @(posedge ref_clk);
      resetn <= 1'b0;
      #1 check("qValid", {23'h0, qValid_q}, 32'h0000_0000);
      check("arMask", {23'h0, arMask_q}, 32'h0000_0000);
      for (int k = 0; k < 9; k++) begin
         check("qBase", qBase_q[k], 32'h0000_0000);
      end
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(12'h000, 32'h0000_0000);
      $display("test mid-run reset done");
      end_of_test();
   end

endmodule // testbench
